// *** rtl/otfr_fault_resp.v ***
// Overtemperature fault limit, its register checks, status flags and shutdown/retry response.
`timescale 1ns/1ps
`default_nettype none
`include "otfr_regs.vh"

module otfr_fault_resp
#(
  parameter TW = 24
)
(
  // Clock and reset.
  input  wire                     clk,
  input  wire                     resetn,
  // Command port from the bus engine.
  input  wire                     cmdWrite,
  input  wire                     cmdRead,
  input  wire [7:0]               cmdCode,
  input  wire [15:0]              cmdWdata,
  output reg  [15:0]              cmdRdata,
  output reg                      cmdRvalid,
  // Temperature inputs.
  input  wire [`OTFR_MANT_HI:0]   tempC,
  input  wire [`OTFR_MANT_HI:0]   warnLimitC,
  input  wire                     bandgapOtPin,
  // Converter control.
  input  wire                     opCommandOn,
  input  wire [TW-1:0]            tonRiseCycles,
  output reg                      powerEnable,
  output reg                      softStartReq,
  // Status flags and alert line.
  input  wire                     tempAlertMask,
  output reg                      commFaultFlag,
  output reg                      invalidDataFlag,
  output reg                      tempSummaryFlag,
  output reg                      tempFaultFlag,
  output wire                     smbAlertOut,
  output wire                     smbAlertOe,
  // Nonvolatile store request.
  output reg                      nvStore,
  output reg  [`OTFR_MANT_HI:0]   nvLimit,
  output reg                      nvEnable,
  output reg                      nvRetry
);

  // Response state machine, one-hot.
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_OFF   = 4'b0010;
  localparam [3:0] ST_COOL  = 4'b0100;
  localparam [3:0] ST_DELAY = 4'b1000;

  // Stored register fields.
  reg [`OTFR_MANT_HI:0] limitC;
  reg                   respEnable;
  reg                   retryBit;

  // Bandgap pin synchroniser.
  reg                   bgMeta;
  reg                   bgSync;

  // State machine.
  reg [3:0]             state;
  reg [3:0]             next_state;
  reg                   timerStart;

  wire                  sensorFault;
  wire                  timerDone;
  wire                  timerBusy;
  wire                  writeLimit;
  wire                  writeAction;
  wire                  limitOk;
  wire                  actionOk;
  wire                  clearFaults;
  wire                  shutdownCause;
  wire                  faultPresent;
  wire [2:0]            retryField;
  wire [7:0]            actionValue;
  wire                  alertActive;

  // Retry fields are valid only when all three bits agree.
  function retryLegal;
    input [2:0] f;
    begin
      retryLegal = (f == `OTFR_RETRY_NONE) || (f == `OTFR_RETRY_ALWAYS);
    end
  endfunction

  // Expands the single stored retry bit to a three-bit field.
  function [2:0] expandBit;
    input b;
    begin
      expandBit = {b, b, b};
    end
  endfunction

  // Trip and hysteresis on the externally sensed temperature.
  otfr_temp_compare u_compare
  (
    .clk         (clk),
    .resetn      (resetn),
    .tempC       (tempC),
    .limitC      (limitC),
    .faultActive (sensorFault)
  );

  // Rise-time interval counter for the retry delay.
  otfr_retry_timer #(.TW(TW)) u_timer
  (
    .clk            (clk),
    .resetn         (resetn),
    .start          (timerStart),
    .abort          (!opCommandOn),
    .intervals      (expandBit(retryBit)),
    .intervalCycles (tonRiseCycles),
    .done           (timerDone),
    .busy           (timerBusy)
  );

  // Command decode and validity checks.
  assign writeLimit  = cmdWrite && (cmdCode == `OTFR_CMD_FAULT_LIMIT);
  assign writeAction = cmdWrite && (cmdCode == `OTFR_CMD_FAULT_ACTION);
  assign clearFaults = cmdWrite && (cmdCode == `OTFR_CMD_CLEAR_FAULTS);
  // Exponent bits of the write are ignored; only the mantissa is judged.
  assign limitOk     = (cmdWdata[`OTFR_MANT_HI:0] > warnLimitC) &&
                       (cmdWdata[`OTFR_MANT_HI:0] >= `OTFR_LIMIT_MIN) &&
                       (cmdWdata[`OTFR_MANT_HI:0] <= `OTFR_LIMIT_MAX);
  assign retryField  = cmdWdata[`OTFR_RETRY_HI:`OTFR_RETRY_LO];
  assign actionOk    = retryLegal(retryField);

  // Read view of the action register: bit 6 zero, delay bits mirror bit 5.
  assign actionValue = {respEnable, 1'b0, expandBit(retryBit), expandBit(retryBit)};

  // Bandgap faults shut down regardless of the enable bit; sensor faults only when enabled.
  assign shutdownCause = (sensorFault && respEnable) || bgSync;
  assign faultPresent  = sensorFault || bgSync;

  // Register writes; a refused write leaves the stored value untouched.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      limitC     <= `OTFR_LIMIT_RESET;
      respEnable <= 1'b0;
      retryBit   <= 1'b1;
    end
    else
    begin
      if (writeLimit && limitOk)
        limitC <= cmdWdata[`OTFR_MANT_HI:0];
      if (writeAction && actionOk)
      begin
        respEnable <= cmdWdata[`OTFR_ENABLE_BIT];
        retryBit   <= cmdWdata[`OTFR_RETRY_HI];
      end
    end
  end

  // Read data is registered and valid for one cycle after the read strobe.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      cmdRdata  <= 16'h0000;
      cmdRvalid <= 1'b0;
    end
    else
    begin
      cmdRvalid <= cmdRead;
      if (cmdRead)
      begin
        case (cmdCode)
          `OTFR_CMD_FAULT_LIMIT:  cmdRdata <= {`OTFR_EXP_ZERO, limitC};
          `OTFR_CMD_FAULT_ACTION: cmdRdata <= {8'h00, actionValue};
          default:                cmdRdata <= 16'h0000;
        endcase
      end
    end
  end

  // Status flags. A new event in the clearing cycle wins over the clear.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      commFaultFlag   <= 1'b0;
      invalidDataFlag <= 1'b0;
      tempSummaryFlag <= 1'b0;
      tempFaultFlag   <= 1'b0;
    end
    else
    begin
      if ((writeLimit && !limitOk) || (writeAction && !actionOk))
      begin
        commFaultFlag   <= 1'b1;
        invalidDataFlag <= 1'b1;
      end
      else if (clearFaults)
      begin
        commFaultFlag   <= 1'b0;
        invalidDataFlag <= 1'b0;
      end
      // The fault flag re-asserts while the latched condition persists.
      if (sensorFault)
      begin
        tempSummaryFlag <= 1'b1;
        tempFaultFlag   <= 1'b1;
      end
      else if (clearFaults)
      begin
        tempSummaryFlag <= 1'b0;
        tempFaultFlag   <= 1'b0;
      end
    end
  end

  // Alert is open drain: driven low while any unmasked flag is set.
  assign alertActive = commFaultFlag || invalidDataFlag ||
                       (!tempAlertMask && (tempSummaryFlag || tempFaultFlag));
  assign smbAlertOut = 1'b0;
  assign smbAlertOe  = alertActive;

  // Two-flop synchroniser for the asynchronous bandgap detector.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      bgMeta <= 1'b0;
      bgSync <= 1'b0;
    end
    else
    begin
      bgMeta <= bandgapOtPin;
      bgSync <= bgMeta;
    end
  end

  // Response sequencing. Turning the converter off abandons any retry in progress.
  always @*
  begin
    next_state = state;
    timerStart = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (opCommandOn && shutdownCause)
        begin
          if (retryBit)
            next_state = ST_COOL;
          else
            next_state = ST_OFF;
        end
      end
      ST_OFF:
      begin
        // Stays off until software clears the faults with no fault present, or the converter is commanded off.
        if (!opCommandOn || (clearFaults && !faultPresent))
          next_state = ST_RUN;
      end
      ST_COOL:
      begin
        if (!opCommandOn)
          next_state = ST_RUN;
        else if (!faultPresent)
        begin
          timerStart = 1'b1;
          next_state = ST_DELAY;
        end
      end
      ST_DELAY:
      begin
        if (!opCommandOn)
          next_state = ST_RUN;
        else if (shutdownCause)
          next_state = ST_COOL;
        else if (timerDone)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  // State register and converter control outputs.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state        <= ST_RUN;
      powerEnable  <= 1'b0;
      softStartReq <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      powerEnable  <= opCommandOn && (next_state == ST_RUN) && !(state == ST_RUN && shutdownCause);
      softStartReq <= (state == ST_DELAY) && (next_state == ST_RUN) && opCommandOn;
    end
  end

  // Snapshot of the stored settings on the store-all command.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      nvStore  <= 1'b0;
      nvLimit  <= `OTFR_LIMIT_RESET;
      nvEnable <= 1'b0;
      nvRetry  <= 1'b1;
    end
    else
    begin
      nvStore <= cmdWrite && (cmdCode == `OTFR_CMD_STORE_ALL);
      if (cmdWrite && (cmdCode == `OTFR_CMD_STORE_ALL))
      begin
        nvLimit  <= limitC;
        nvEnable <= respEnable;
        nvRetry  <= retryBit;
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/otfr_regs.vh ***
// Command codes, field positions, reset values and limits of the overtemperature fault block.
`ifndef OTFR_REGS_VH
`define OTFR_REGS_VH

// Command codes on the management command port.
`define OTFR_CMD_CLEAR_FAULTS   8'h03
`define OTFR_CMD_STORE_ALL      8'h11
`define OTFR_CMD_FAULT_LIMIT    8'h4f
`define OTFR_CMD_FAULT_ACTION   8'h50

// Limit word layout: 5-bit read-only exponent above an 11-bit mantissa.
`define OTFR_MANT_W             11
`define OTFR_MANT_HI            10
`define OTFR_EXP_ZERO           5'h00
`define OTFR_LIMIT_RESET        11'h091
`define OTFR_LIMIT_MIN          11'h078
`define OTFR_LIMIT_MAX          11'h0a5
`define OTFR_HYSTERESIS         11'h014

// Action register layout.
`define OTFR_ACTION_RESET       8'h3f
`define OTFR_ENABLE_BIT         7
`define OTFR_ZERO_BIT           6
`define OTFR_RETRY_HI           5
`define OTFR_RETRY_LO           3
`define OTFR_RETRY_NONE         3'h0
`define OTFR_RETRY_ALWAYS       3'h7

// Retry delay counter width.
`define OTFR_DELAY_W            3

`endif

// *** rtl/otfr_temp_compare.v ***
// Overtemperature trip with a latched flag and a fixed release hysteresis.
`timescale 1ns/1ps
`default_nettype none
`include "otfr_regs.vh"

module otfr_temp_compare
(
  // Clock and reset.
  input  wire                     clk,
  input  wire                     resetn,
  // Temperature and threshold, whole degrees.
  input  wire [`OTFR_MANT_HI:0]   tempC,
  input  wire [`OTFR_MANT_HI:0]   limitC,
  // Latched fault condition.
  output reg                      faultActive
);

  wire [`OTFR_MANT_HI:0] releaseC;
  wire                   aboveLimit;
  wire                   belowRelease;

  // Limits never go under the minimum, so the subtraction cannot wrap.
  assign releaseC     = limitC - `OTFR_HYSTERESIS;
  assign aboveLimit   = (tempC > limitC);
  assign belowRelease = (tempC <= releaseC);

  // Trip above the limit; release only once cooled by the hysteresis.
  always @(posedge clk)
  begin
    if (!resetn)
      faultActive <= 1'b0;
    else if (aboveLimit)
      faultActive <= 1'b1;
    else if (belowRelease)
      faultActive <= 1'b0;
  end

endmodule
`default_nettype wire

// *** rtl/otfr_retry_timer.v ***
// Counts a number of rise-time intervals before a soft-start retry.
`timescale 1ns/1ps
`default_nettype none
`include "otfr_regs.vh"

module otfr_retry_timer
#(
  parameter TW = 24
)
(
  // Clock and reset.
  input  wire                     clk,
  input  wire                     resetn,
  // Control.
  input  wire                     start,
  input  wire                     abort,
  input  wire [`OTFR_DELAY_W-1:0] intervals,
  input  wire [TW-1:0]            intervalCycles,
  // Status.
  output reg                      done,
  output reg                      busy
);

  reg [TW-1:0]            cycleCount;
  reg [`OTFR_DELAY_W-1:0] intervalsLeft;

  wire lastCycle;

  // A zero interval length is treated as one cycle so the timer always ends.
  assign lastCycle = (cycleCount <= {{(TW-1){1'b0}}, 1'b1});

  // Interval down-counter; done pulses for one cycle at the end.
  always @(posedge clk)
  begin
    if (!resetn || abort)
    begin
      busy          <= 1'b0;
      done          <= 1'b0;
      cycleCount    <= {TW{1'b0}};
      intervalsLeft <= {`OTFR_DELAY_W{1'b0}};
    end
    else if (start)
    begin
      busy          <= (intervals != {`OTFR_DELAY_W{1'b0}});
      done          <= (intervals == {`OTFR_DELAY_W{1'b0}});
      cycleCount    <= intervalCycles;
      intervalsLeft <= intervals;
    end
    else if (busy && lastCycle)
    begin
      cycleCount    <= intervalCycles;
      intervalsLeft <= intervalsLeft - 1'b1;
      busy          <= (intervalsLeft != {{(`OTFR_DELAY_W-1){1'b0}}, 1'b1});
      done          <= (intervalsLeft == {{(`OTFR_DELAY_W-1){1'b0}}, 1'b1});
    end
    else
    begin
      done <= 1'b0;
      if (busy)
        cycleCount <= cycleCount - 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** dv/otfr_fault_resp_properties.sv ***
// Port assertions for the overtemperature fault block.
`timescale 1ns/1ps
`default_nettype none

module otfr_fault_resp_properties
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        resetn,
  // Command port.
  input wire logic        cmdWrite,
  input wire logic        cmdRead,
  input wire logic [7:0]  cmdCode,
  input wire logic [15:0] cmdWdata,
  input wire logic [15:0] cmdRdata,
  input wire logic        cmdRvalid,
  // Temperature and converter.
  input wire logic [10:0] tempC,
  input wire logic [10:0] warnLimitC,
  input wire logic        bandgapOtPin,
  input wire logic        tempAlertMask,
  input wire logic        powerEnable,
  input wire logic        softStartReq,
  // Flags and store.
  input wire logic        commFaultFlag,
  input wire logic        invalidDataFlag,
  input wire logic        tempSummaryFlag,
  input wire logic        tempFaultFlag,
  input wire logic        smbAlertOe,
  input wire logic        nvStore,
  input wire logic [10:0] nvLimit
);
  logic [10:0] lim;
  wire         limWr = cmdWrite && cmdCode == 8'h4f;
  wire         actWr = cmdWrite && cmdCode == 8'h50;
  wire  [10:0] wm    = cmdWdata[10:0];
  wire  [2:0]  rs    = cmdWdata[5:3];

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Mirror of the accepted limit, so trips are judged against what the host set.
  always @(posedge clk)
    if (!resetn)
      lim <= 11'h091;
    else if (limWr && wm > warnLimitC && wm >= 11'h078 && wm <= 11'h0a5)
      lim <= wm;

  AST_LIMIT_LOW: assert property (
    limWr && wm <= warnLimitC |=> commFaultFlag && invalidDataFlag)
    else $error("Low limit write was not flagged.");
  AST_RETRY_BAD: assert property (
    actWr && rs != 3'h0 && rs != 3'h7 |=> commFaultFlag && invalidDataFlag)
    else $error("Bad retry write was not flagged.");
  AST_ALERT_CML: assert property (commFaultFlag |-> smbAlertOe)
    else $error("Alert missing on comm fault.");
  AST_TRIP: assert property (
    tempC > lim |-> ##2 tempFaultFlag && tempSummaryFlag)
    else $error("Overtemperature did not trip.");
  AST_HOLD: assert property (
    tempC > lim ##1 (tempC > lim - 11'h014) [*3] |=> tempFaultFlag)
    else $error("Fault flag released inside hysteresis.");
  AST_ALERT_TEMP: assert property (tempFaultFlag && !tempAlertMask |-> smbAlertOe)
    else $error("Alert missing on temperature fault.");
  AST_LIMIT_READ: assert property (
    cmdRead && cmdCode == 8'h4f |=> cmdRvalid && cmdRdata == {5'h00, lim})
    else $error("Limit read is wrong.");
  AST_ACTION_READ: assert property (
    cmdRead && cmdCode == 8'h50 |=> cmdRdata[15:8] == 8'h00 && !cmdRdata[6]
      && cmdRdata[2:0] == cmdRdata[5:3] && (cmdRdata[5:3] == 3'h0 || cmdRdata[5:3] == 3'h7))
    else $error("Action read has bad fields.");
  AST_STORE: assert property (cmdWrite && cmdCode == 8'h11 |=> nvStore && nvLimit == lim)
    else $error("Store did not snapshot the limit.");
  AST_BANDGAP: assert property (bandgapOtPin [*3] |=> !powerEnable)
    else $error("Bandgap fault did not shut down.");

  CV_BAD_RETRY: cover property (actWr && rs == 3'h2);
  CV_RESTART: cover property (softStartReq);
  CV_BANDGAP: cover property (bandgapOtPin && !powerEnable);
endmodule

bind otfr_fault_resp otfr_fault_resp_properties otfr_fault_resp_properties_inst (
  .clk(clk), .resetn(resetn), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
  .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .tempC(tempC),
  .warnLimitC(warnLimitC), .bandgapOtPin(bandgapOtPin), .tempAlertMask(tempAlertMask),
  .powerEnable(powerEnable), .softStartReq(softStartReq), .commFaultFlag(commFaultFlag),
  .invalidDataFlag(invalidDataFlag), .tempSummaryFlag(tempSummaryFlag),
  .tempFaultFlag(tempFaultFlag), .smbAlertOe(smbAlertOe), .nvStore(nvStore), .nvLimit(nvLimit));
`default_nettype wire

// *** dv/otfr_host_model.sv ***
// Host controller model issuing management commands to the fault block.
`timescale 1ns/1ps
`default_nettype none

module otfr_host_model
(
  // Clock.
  input  wire logic        clk,
  // Command strobes and data towards the device.
  output var  logic        cmdWrite,
  output var  logic        cmdRead,
  output var  logic [7:0]  cmdCode,
  output var  logic [15:0] cmdWdata,
  // Read answer.
  input  wire logic [15:0] cmdRdata,
  input  wire logic        cmdRvalid
);
  // Idle at time zero.
  initial
  begin
    cmdWrite = 1'b0;
    cmdRead  = 1'b0;
    cmdCode  = 8'h00;
    cmdWdata = 16'hffff;
  end

  // One write pulse; idle data is inverted so a stale word never looks fresh.
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmdCode  = code;
    cmdWdata = (code == 8'h4f) ? {5'h00, data[10:0]} : data;
    cmdWrite = 1'b1;
    @(negedge clk);
    cmdWrite = 1'b0;
    cmdWdata = ~cmdWdata;
  endtask

  // One read pulse; the answer is taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic vld);
    @(negedge clk);
    cmdCode = code;
    cmdRead = 1'b1;
    @(negedge clk);
    cmdRead = 1'b0;
    data    = cmdRdata;
    vld     = cmdRvalid;
  endtask
endmodule
`default_nettype wire

// *** dv/otfr_fault_resp_test.sv ***
// Self-checking testbench of the overtemperature fault block.
`timescale 1ns/1ps
`default_nettype none

module otfr_fault_resp_test;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmdWrite, cmdRead, cmdRvalid, vld, bad;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWdata, cmdRdata, rdv, expLim, expAct;
  logic [10:0] tempC = 11'd25, warnLimitC = 11'd120, nvLimit;
  logic        bandgapOtPin = 1'b0, opCommandOn = 1'b1, tempAlertMask = 1'b0;
  logic [23:0] tonRiseCycles = 24'd4;
  logic        powerEnable, softStartReq, commFaultFlag, invalidDataFlag, tempSummaryFlag;
  logic        tempFaultFlag, smbAlertOut, smbAlertOe, nvStore, nvEnable, nvRetry;
  int          errorCnt = 0, samplesChecked = 0, cycles = 0, n;
  int          lw[6] = '{100, 100, 100, 100, 140, 140};
  int          ld[6] = '{120, 119, 165, 166, 140, 141};

  otfr_fault_resp #(.TW(24)) otfr_fault_resp_inst (
    .clk(clk), .resetn(resetn), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .tempC(tempC),
    .warnLimitC(warnLimitC), .bandgapOtPin(bandgapOtPin), .opCommandOn(opCommandOn),
    .tonRiseCycles(tonRiseCycles), .powerEnable(powerEnable), .softStartReq(softStartReq),
    .tempAlertMask(tempAlertMask), .commFaultFlag(commFaultFlag),
    .invalidDataFlag(invalidDataFlag), .tempSummaryFlag(tempSummaryFlag),
    .tempFaultFlag(tempFaultFlag), .smbAlertOut(smbAlertOut), .smbAlertOe(smbAlertOe),
    .nvStore(nvStore), .nvLimit(nvLimit), .nvEnable(nvEnable), .nvRetry(nvRetry));

  otfr_host_model otfr_host_model_inst (
    .clk(clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid));

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Hang guard; the full sequence needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errorCnt++;
      printVerdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Status bits gathered so one compare covers flags, alert and regulation.
  function automatic logic [5:0] st();
    return {commFaultFlag, invalidDataFlag, tempSummaryFlag, tempFaultFlag, smbAlertOe, powerEnable};
  endfunction

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    otfr_host_model_inst.wr(c, d);
  endtask

  task automatic rdChk(input logic [7:0] c, input logic [15:0] e);
    otfr_host_model_inst.rd(c, rdv, vld);
    chk(vld, 1'b1);
    chk(rdv, e);
  endtask

  // Bounded wait on regulation (0) or on a retry start (1).
  task automatic waitSig(input int which, input logic v, input int lim);
    n = 0;
    while ((which ? softStartReq : powerEnable) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  initial
  begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    waitSig(0, 1'b1, 60);
    rdChk(8'h4f, 16'h0091);
    rdChk(8'h50, 16'h003f);
    chk(st(), 6'b000001);
    // Limit boundaries against the range and the warning limit.
    expLim = 16'h0091;
    foreach (ld[i])
    begin
      warnLimitC = 11'(lw[i]);
      bad = ld[i] <= lw[i] || ld[i] < 120 || ld[i] > 165;
      wr(8'h4f, 16'(ld[i]));
      chk(st(), bad ? 6'b110011 : 6'b000001);
      if (!bad)
        expLim = 16'(ld[i]);
      rdChk(8'h4f, expLim);
      wr(8'h03, 16'h0000);
    end
    warnLimitC = 11'd120;
    wr(8'h4f, 16'h0091);
    // Every retry pattern, with the zero bit and delay bits written as junk.
    expAct = 16'h003f;
    for (int r = 0; r < 8; r++)
    begin
      wr(8'h50, {8'h00, 2'b11, 3'(r), 3'b010});
      bad = r != 0 && r != 7;
      if (!bad)
        expAct = {8'h00, 2'b10, {2{3'(r)}}};
      chk(st(), bad ? 6'b110011 : 6'b000001);
      rdChk(8'h50, expAct);
      wr(8'h03, 16'h0000);
    end
    wr(8'h11, 16'h0000);
    chk({nvStore, nvEnable, nvRetry, nvLimit}, {3'b111, 11'd145});
    // Ignore mode: flags and alert, regulation untouched, then hysteresis.
    wr(8'h50, 16'h0038);
    tempC = 11'd150;
    repeat (3) @(negedge clk);
    chk(st(), 6'b001111);
    chk({smbAlertOut, smbAlertOe}, 2'b01);
    tempAlertMask = 1'b1;
    @(negedge clk);
    chk(smbAlertOe, 1'b0);
    tempAlertMask = 1'b0;
    tempC = 11'd126;
    repeat (3) @(negedge clk);
    wr(8'h03, 16'h0000);
    chk(tempFaultFlag, 1'b1);
    tempC = 11'd125;
    repeat (3) @(negedge clk);
    wr(8'h03, 16'h0000);
    chk(st(), 6'b000001);
    // Shutdown with endless retry after seven rise intervals of four cycles.
    wr(8'h50, 16'h00bf);
    tempC = 11'd150;
    waitSig(0, 1'b0, 8);
    chk(powerEnable, 1'b0);
    tempC = 11'd100;
    waitSig(1, 1'b1, 60);
    chk(n >= 28 && n <= 40, 1'b1);
    waitSig(0, 1'b1, 3);
    chk(powerEnable, 1'b1);
    wr(8'h03, 16'h0000);
    // No retry: stays off until faults are cleared.
    wr(8'h50, 16'h0080);
    tempC = 11'd150;
    waitSig(0, 1'b0, 8);
    tempC = 11'd100;
    waitSig(1, 1'b1, 60);
    chk({n == 60, powerEnable}, 2'b10);
    wr(8'h03, 16'h0000);
    waitSig(0, 1'b1, 60);
    chk(powerEnable, 1'b1);
    // Bandgap fault is never ignored and restarts once cool.
    wr(8'h50, 16'h0038);
    bandgapOtPin = 1'b1;
    waitSig(0, 1'b0, 8);
    chk(powerEnable, 1'b0);
    bandgapOtPin = 1'b0;
    waitSig(0, 1'b1, 60);
    chk(powerEnable, 1'b1);
    // Commanded off while cooling: the retry is abandoned until turned on again.
    wr(8'h50, 16'h00bf);
    tempC = 11'd150;
    waitSig(0, 1'b0, 8);
    tempC = 11'd100;
    opCommandOn = 1'b0;
    waitSig(1, 1'b1, 40);
    chk({n == 40, powerEnable}, 2'b10);
    opCommandOn = 1'b1;
    waitSig(0, 1'b1, 4);
    chk(powerEnable, 1'b1);
    printVerdict();
  end
endmodule
`default_nettype wire
